// >>> hw/fts_pkg.sv
// constants and types of the fault and thermal supervisor
package fts_pkg;
  localparam int          CORE_CLK_HZ     = 50_000_000;
  localparam int          NUM_CH          = 8;
  localparam int          WD_TIMEOUT_US   = 1000;
  localparam int          WD_TIMEOUT_CYC  = (CORE_CLK_HZ / 1_000_000) * WD_TIMEOUT_US;
  localparam int          REFRESH_US      = 100;
  localparam int          REFRESH_CYC     = (CORE_CLK_HZ / 1_000_000) * REFRESH_US;
  localparam logic [31:0] VERSION_ID      = 32'h0000_0001;
  localparam logic [3:0]  ADDR_CTRL       = 4'h0;
  localparam logic [3:0]  ADDR_STATUS     = 4'h4;
  localparam logic [3:0]  ADDR_CHSTAT     = 4'h8;
  localparam logic [3:0]  ADDR_VERSION    = 4'hC;
  localparam int          CTRL_SCM_BIT    = 0;
  localparam int          CTRL_OUTEN_BIT  = 1;
  localparam logic [1:0]  CTRL_RESET      = 2'h2;
  localparam int          ST_FAULT_BIT    = 0;
  localparam int          ST_COMM_BIT     = 1;
  localparam int          ST_CASE_BIT     = 2;
  localparam int          ST_WD_BIT       = 3;
  localparam int          ST_SUSP_BIT     = 4;
  localparam logic [1:0]  AXI_OKAY        = 2'h0;
  localparam logic [1:0]  AXI_SLVERR      = 2'h2;
  typedef enum logic [2:0] {
    FTS_CASE_RUN  = 3'h1,
    FTS_CASE_OFF  = 3'h2,
    FTS_CASE_WAIT = 3'h4
  } fts_case_e;
endpackage

// >>> hw/fts_top.sv
// fault reporting and thermal protection supervisor, single file
`timescale 1ns/1ps
// Operation
// - fault line open-drain, pull low only
// - fault on junction overheat or case shutdown
// - fault on corrupted cross-barrier transfer
// - corruption holds outputs, refresh corruption clears
// - thermal status refreshed each transfer
// - latch high, sync low suspends transfers in sync mode or while output enable is set
// - channel thermal protection always active
// - junction shutdown/restart cycling per channel
// - case shutdown restarts when all cooled
// - latch high sync low loads, stops refresh while output enable is set
// - watchdog timeout disables outputs until next valid update or refresh
module fts_top
  import fts_pkg::*;
#(
  parameter int WD_CYC  = WD_TIMEOUT_CYC,
  parameter int REF_CYC = REFRESH_CYC
) (
  input  wire logic              CORE_CLK,
  input  wire logic              NRST,
  input  wire logic [NUM_CH-1:0] IN_DATA,
  input  wire logic              LOAD_N,
  input  wire logic              SYNC_N,
  input  wire logic [NUM_CH-1:0] JUNC_OVER_SHUTDOWN,
  input  wire logic [NUM_CH-1:0] JUNC_BELOW_RESTART,
  input  wire logic              CASE_OVER_SHUTDOWN,
  input  wire logic              CASE_BELOW_RESET,
  input  wire logic              XFER_CORRUPT,
  output logic [NUM_CH-1:0]      CH_OUT,
  output logic                   FAULT_N_O,
  output logic                   FAULT_N_OE,
  input  wire logic [3:0]        S_AXI_AWADDR,
  input  wire logic              S_AXI_AWVALID,
  output logic                   S_AXI_AWREADY,
  input  wire logic [31:0]       S_AXI_WDATA,
  input  wire logic [3:0]        S_AXI_WSTRB,
  input  wire logic              S_AXI_WVALID,
  output logic                   S_AXI_WREADY,
  output logic [1:0]             S_AXI_BRESP,
  output logic                   S_AXI_BVALID,
  input  wire logic              S_AXI_BREADY,
  input  wire logic [3:0]        S_AXI_ARADDR,
  input  wire logic              S_AXI_ARVALID,
  output logic                   S_AXI_ARREADY,
  output logic [31:0]            S_AXI_RDATA,
  output logic [1:0]             S_AXI_RRESP,
  output logic                   S_AXI_RVALID,
  input  wire logic              S_AXI_RREADY
);
  initial begin
    if (WD_CYC < 2 || REF_CYC < 2 || REF_CYC >= WD_CYC) begin
      $error("fts_top: bad timing parameters");
    end
  end

  logic [1:0]        ctrl_ff;
  logic              aw_got_ff;
  logic              w_got_ff;
  logic [3:0]        aw_addr_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic [NUM_CH-1:0] in_buf_ff;
  logic [NUM_CH-1:0] tx_buf_ff;
  logic [NUM_CH-1:0] cmd_ff;
  logic [NUM_CH-1:0] junc_off_ff;
  logic [NUM_CH-1:0] case_mask_ff;
  fts_case_e         case_st_ff;
  logic [NUM_CH-1:0] therm_seen_ff;
  logic              case_seen_ff;
  logic              comm_err_ff;
  logic [31:0]       ref_cnt_ff;
  logic [31:0]       wd_cnt_ff;
  logic              wd_exp_ff;
  logic              outen_d_ff;

  logic synchronous_update_mode;
  logic outen;
  logic suspend;
  logic load_tx;
  logic refresh;
  logic xfer;
  logic upd_xfer;
  logic good;
  logic fault;
  logic wr_do;
  logic load_seen_ff;

  assign synchronous_update_mode     = ctrl_ff[CTRL_SCM_BIT];
  assign outen   = ctrl_ff[CTRL_OUTEN_BIT];
  assign load_tx = LOAD_N && !SYNC_N && outen;
  assign suspend = synchronous_update_mode && LOAD_N && !SYNC_N;
  assign refresh = (ref_cnt_ff == 32'(REF_CYC - 1)) && !load_tx;
  assign upd_xfer = (synchronous_update_mode ? (!outen_d_ff && 1'b0) : 1'b0)
                  | ((!LOAD_N && !SYNC_N) && !synchronous_update_mode);
  assign xfer    = !suspend && (refresh || upd_xfer || (synchronous_update_mode && SYNC_N && load_seen_ff));
  assign good    = xfer && !XFER_CORRUPT;

  // a load in sync mode arms the transfer that follows the sync release
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      load_seen_ff <= 1'b0;
    end else if (load_tx) begin
      load_seen_ff <= 1'b1;
    end else if (xfer) begin
      load_seen_ff <= 1'b0;
    end
  end

  // input and transmission buffers
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      in_buf_ff <= '0;
      tx_buf_ff <= '0;
    end else begin
      if (!LOAD_N) begin
        in_buf_ff <= IN_DATA;
      end
      if (load_tx) begin
        tx_buf_ff <= in_buf_ff;
      end
    end
  end

  // periodic refresh counter, stopped while loading
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      ref_cnt_ff <= '0;
    end else if (load_tx) begin
      ref_cnt_ff <= ref_cnt_ff;
    end else if (ref_cnt_ff == 32'(REF_CYC - 1)) begin
      ref_cnt_ff <= '0;
    end else begin
      ref_cnt_ff <= ref_cnt_ff + 32'd1;
    end
  end

  // process-side command: corrupted data holds, corrupted refresh clears
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      cmd_ff      <= '0;
      comm_err_ff <= 1'b0;
      outen_d_ff  <= 1'b0;
    end else begin
      outen_d_ff <= outen;
      if (!outen) begin
        cmd_ff <= '0;
      end else if (xfer && XFER_CORRUPT && refresh) begin
        cmd_ff <= '0;
      end else if (good && upd_xfer) begin
        cmd_ff <= IN_DATA;
      end else if (good && !refresh) begin
        cmd_ff <= tx_buf_ff;
      end
      if (xfer) begin
        comm_err_ff <= XFER_CORRUPT;
      end
    end
  end

  // watchdog on valid updates and refreshes
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      wd_cnt_ff <= '0;
      wd_exp_ff <= 1'b0;
    end else if (good) begin
      wd_cnt_ff <= '0;
      wd_exp_ff <= 1'b0;
    end else if (wd_cnt_ff == 32'(WD_CYC - 1)) begin
      wd_exp_ff <= 1'b1;
    end else begin
      wd_cnt_ff <= wd_cnt_ff + 32'd1;
    end
  end

  // per-channel junction protection, runs regardless of link state
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      junc_off_ff <= '0;
    end else begin
      junc_off_ff <= (junc_off_ff | JUNC_OVER_SHUTDOWN) & ~JUNC_BELOW_RESTART;
    end
  end

  // case shutdown of faulted channels
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      case_st_ff   <= FTS_CASE_RUN;
      case_mask_ff <= '0;
    end else begin
      unique case (case_st_ff)
        FTS_CASE_RUN: begin
          if (CASE_OVER_SHUTDOWN && |junc_off_ff) begin
            case_mask_ff <= junc_off_ff;
            case_st_ff   <= FTS_CASE_OFF;
          end
        end
        FTS_CASE_OFF: begin
          case_mask_ff <= case_mask_ff | junc_off_ff;
          if (!CASE_OVER_SHUTDOWN) begin
            case_st_ff <= FTS_CASE_WAIT;
          end
        end
        FTS_CASE_WAIT: begin
          if (CASE_OVER_SHUTDOWN) begin
            case_st_ff <= FTS_CASE_OFF;
          end else if (CASE_BELOW_RESET && &(JUNC_BELOW_RESTART | ~case_mask_ff)) begin
            case_mask_ff <= '0;
            case_st_ff   <= FTS_CASE_RUN;
          end
        end
        default: begin
          case_st_ff <= FTS_CASE_RUN;
        end
      endcase
    end
  end

  // thermal status seen by logic side, refreshed per transfer
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      therm_seen_ff <= '0;
      case_seen_ff  <= 1'b0;
    end else if (xfer) begin
      therm_seen_ff <= JUNC_OVER_SHUTDOWN | junc_off_ff;
      case_seen_ff  <= (case_st_ff != FTS_CASE_RUN);
    end
  end

  assign fault = |therm_seen_ff || case_seen_ff || comm_err_ff;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      CH_OUT     <= '0;
      FAULT_N_OE <= 1'b0;
    end else begin
      CH_OUT     <= cmd_ff & ~junc_off_ff & ~case_mask_ff & {NUM_CH{!wd_exp_ff && outen}};
      FAULT_N_OE <= fault;
    end
  end
  assign FAULT_N_O = 1'b0;

  // axi4-lite slave, single outstanding access each way
  assign S_AXI_AWREADY = !aw_got_ff && !S_AXI_BVALID;
  assign S_AXI_WREADY  = !w_got_ff && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;
  assign wr_do         = aw_got_ff && w_got_ff && !S_AXI_BVALID;

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      aw_got_ff    <= 1'b0;
      w_got_ff     <= 1'b0;
      aw_addr_ff   <= '0;
      w_data_ff    <= '0;
      w_strb_ff    <= '0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP  <= AXI_OKAY;
      ctrl_ff      <= CTRL_RESET;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_got_ff  <= 1'b1;
        w_data_ff <= S_AXI_WDATA;
        w_strb_ff <= S_AXI_WSTRB;
      end
      if (wr_do) begin
        aw_got_ff    <= 1'b0;
        w_got_ff     <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        if (aw_addr_ff == ADDR_CTRL) begin
          S_AXI_BRESP <= AXI_OKAY;
          if (w_strb_ff[0]) begin
            ctrl_ff <= w_data_ff[1:0];
          end
        end else if (aw_addr_ff == ADDR_STATUS || aw_addr_ff == ADDR_CHSTAT
                     || aw_addr_ff == ADDR_VERSION) begin
          S_AXI_BRESP <= AXI_OKAY;
        end else begin
          S_AXI_BRESP <= AXI_SLVERR;
        end
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA  <= '0;
      S_AXI_RRESP  <= AXI_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RRESP  <= AXI_OKAY;
      unique case (S_AXI_ARADDR)
        ADDR_CTRL:    S_AXI_RDATA <= {30'h0000_0000, ctrl_ff};
        ADDR_STATUS:  S_AXI_RDATA <= {27'h000_0000, suspend, wd_exp_ff,
                                      case_seen_ff, comm_err_ff, fault};
        ADDR_CHSTAT:  S_AXI_RDATA <= {16'h0000, therm_seen_ff, CH_OUT};
        ADDR_VERSION: S_AXI_RDATA <= VERSION_ID;
        default: begin
          S_AXI_RDATA <= '0;
          S_AXI_RRESP <= AXI_SLVERR;
        end
      endcase
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end
endmodule

// >>> testbench/fault_thermal_supervisor_test.sv
// self-checking testbench for the fault and thermal supervisor
`timescale 1ns/1ps
module fault_thermal_supervisor_test import fts_pkg::*;;
  localparam int WD  = 40;
  localparam int REF = 8;
  logic        core_clk, nrst, load_n, sync_n, case_over, case_below, corrupt, fault_line;
  logic        f_o, f_oe, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  in_data, j_over, j_below, ch_out;
  logic [3:0]  awaddr, wstrb, araddr;
  logic [31:0] wdata, rdata, d;
  logic [1:0]  bresp, rresp, r;
  int          bad_count, tests_run, cycles;
  // {inputs, hot channels, expected outputs}
  logic [23:0] rows [6] = '{24'hFF_00FF, 24'hFF_817E, 24'h3C_0C30, 24'h5A_005A,
                            24'h00_FF00, 24'hA5_00A5};
  fts_top #(.WD_CYC(WD), .REF_CYC(REF)) dut (
    .CORE_CLK(core_clk), .NRST(nrst), .IN_DATA(in_data), .LOAD_N(load_n), .SYNC_N(sync_n),
    .JUNC_OVER_SHUTDOWN(j_over), .JUNC_BELOW_RESTART(j_below), .CASE_OVER_SHUTDOWN(case_over),
    .CASE_BELOW_RESET(case_below), .XFER_CORRUPT(corrupt), .CH_OUT(ch_out), .FAULT_N_O(f_o),
    .FAULT_N_OE(f_oe), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr),
    .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
    .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  fts_host_model host (.FAULT_N_O(f_o), .FAULT_N_OE(f_oe), .fault_line(fault_line));
  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      conclude();
    end
  end
  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task conclude();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task drv(input logic l, input logic s);
    @(posedge core_clk);
    {load_n, sync_n} <= {l, s};
  endtask
  // readies are sampled mid-cycle so the edge update cannot race the check
  task axi_wr(input logic [3:0] a, input logic [31:0] v);
    logic aw, wd, b;
    @(posedge core_clk);
    {awaddr, wdata, wstrb} <= {a, v, 4'hF};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(negedge core_clk);
      aw = awvalid & awready;
      wd = wvalid & wready;
      b = bvalid === 1'h1;
      r = bresp;
      @(posedge core_clk);
      if (aw) awvalid <= 1'h0;
      if (wd) wvalid <= 1'h0;
    end while (!b);
    bready <= 1'h0;
  endtask
  task axi_rd(input logic [3:0] a);
    logic ar, b;
    @(posedge core_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(negedge core_clk);
      ar = arvalid & arready;
      b = rvalid === 1'h1;
      {d, r} = {rdata, rresp};
      @(posedge core_clk);
      if (ar) arvalid <= 1'h0;
    end while (!b);
    rready <= 1'h0;
  endtask
  initial begin
    {nrst, load_n, sync_n, case_over, case_below, corrupt} = 6'h1A;
    {in_data, j_over, j_below} = 24'h00_00FF;
    {awaddr, wdata, wstrb, araddr, awvalid, wvalid, bready, arvalid, rready} = '0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'h1;
    idle(1);
    chk("fault_line", fault_line, 1'h1);
    axi_rd(ADDR_CTRL);
    chk("ctrl", d, CTRL_RESET);
    axi_rd(4'h6);
    chk("unmapped_resp", r, AXI_SLVERR);
    $display("test reset done");
    foreach (rows[i]) begin
      drv(1'h0, 1'h0);
      {in_data, j_over} <= rows[i][23:8];
      j_below <= ~rows[i][15:8];
      idle(REF + 6);
      chk("ch_out", ch_out, rows[i][7:0]);
      chk("fault_line", fault_line, !(|rows[i][15:8]));
    end
    $display("test rows done");
    drv(1'h1, 1'h0);
    idle(2);
    drv(1'h0, 1'h0);
    {in_data, corrupt} <= {8'h3C, 1'h1};
    drv(1'h1, 1'h0);
    idle(3);
    chk("ch_out", ch_out, 8'hA5);
    chk("fault_line", fault_line, 1'h0);
    drv(1'h1, 1'h1);
    idle(REF + 6);
    chk("ch_out", ch_out, 8'h00);
    drv(1'h1, 1'h1);
    corrupt <= 1'h0;
    idle(REF + 6);
    chk("fault_line", fault_line, 1'h1);
    $display("test corruption done");
    drv(1'h0, 1'h0);
    in_data <= 8'hFF;
    idle(3);
    drv(1'h0, 1'h0);
    {j_over, j_below} <= 16'h20DF;
    idle(3);
    drv(1'h0, 1'h0);
    {case_over, case_below} <= 2'h2;
    idle(3);
    drv(1'h0, 1'h0);
    {j_over, j_below, case_over} <= {8'h00, 8'hFF, 1'h0};
    idle(REF + 6);
    chk("ch_out", ch_out, 8'hDF);
    chk("fault_line", fault_line, 1'h0);
    drv(1'h0, 1'h0);
    case_below <= 1'h1;
    idle(REF + 6);
    chk("ch_out", ch_out, 8'hFF);
    chk("fault_line", fault_line, 1'h1);
    $display("test case shutdown done");
    drv(1'h1, 1'h0);
    idle(WD + 8);
    chk("ch_out", ch_out, 8'h00);
    drv(1'h0, 1'h0);
    idle(4);
    chk("ch_out", ch_out, 8'hFF);
    $display("test watchdog done");
    drv(1'h1, 1'h1);
    axi_wr(ADDR_CTRL, 32'h0000_0003);
    chk("ctrl_resp", r, AXI_OKAY);
    axi_rd(ADDR_CTRL);
    chk("ctrl", d, 32'h0000_0003);
    drv(1'h0, 1'h1);
    in_data <= 8'h0F;
    idle(2);
    drv(1'h1, 1'h0);
    {j_over, j_below} <= 16'h01FE;
    idle(4);
    chk("ch_out", ch_out, 8'hFE);
    chk("fault_line", fault_line, 1'h1);
    drv(1'h1, 1'h1);
    idle(REF + 6);
    chk("ch_out", ch_out, 8'h0E);
    chk("fault_line", fault_line, 1'h0);
    $display("test sync mode done");
    conclude();
  end
endmodule

// >>> testbench/fts_host_model.sv
// host side model of the shared fault line
`timescale 1ns/1ps
module fts_host_model (
  input  wire logic FAULT_N_O,
  input  wire logic FAULT_N_OE,
  output logic      fault_line
);
  // board pull-up holds the line high when nobody pulls it
  assign fault_line = FAULT_N_OE ? FAULT_N_O : 1'h1;
endmodule

// >>> testbench/fts_props.sv
// assertion checker for the fault and thermal supervisor
`timescale 1ns/1ps
module fts_props
  import fts_pkg::*;
#(
  parameter int WD_CYC  = WD_TIMEOUT_CYC,
  parameter int REF_CYC = REFRESH_CYC
) (
  input wire logic              CORE_CLK,
  input wire logic              NRST,
  input wire logic              LOAD_N,
  input wire logic              SYNC_N,
  input wire logic [NUM_CH-1:0] JUNC_OVER_SHUTDOWN,
  input wire logic              CASE_OVER_SHUTDOWN,
  input wire logic              CASE_BELOW_RESET,
  input wire logic              XFER_CORRUPT,
  input wire logic [NUM_CH-1:0] CH_OUT,
  input wire logic              FAULT_N_O,
  input wire logic              FAULT_N_OE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic pause;
  int   hot_ff;
  int   sus_ff;
  assign pause = LOAD_N && !SYNC_N;
  // pause resets the heat count and advances the suspend count: with output enable set no transfer may happen then
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      hot_ff <= 0;
      sus_ff <= 0;
    end else begin
      hot_ff <= (|JUNC_OVER_SHUTDOWN && !pause && !FAULT_N_OE) ? hot_ff + 1 : 0;
      sus_ff <= !pause ? 0 : (sus_ff < WD_CYC + 8) ? sus_ff + 1 : sus_ff;
    end
  end
  sequence s_case_trip;
    CASE_OVER_SHUTDOWN && |JUNC_OVER_SHUTDOWN;
  endsequence
  sequence s_case_hot;
    !CASE_BELOW_RESET [*3];
  endsequence
  a_fault_pin_low: assert property (FAULT_N_O == 1'h0)
    else $error("fault pin driven high");
  a_fault_on_heat: assert property (hot_ff <= REF_CYC + 3)
    else $error("overheat not reported");
  a_corrupt_fault: assert property (!LOAD_N && !SYNC_N && XFER_CORRUPT |-> ##[1:2] FAULT_N_OE)
    else $error("corruption not reported");
  a_corrupt_hold: assert property (!LOAD_N && !SYNC_N && XFER_CORRUPT |=> $stable(CH_OUT))
    else $error("outputs moved on corrupt data");
  a_suspend_hold: assert property (pause [*3] |-> $stable(FAULT_N_OE))
    else $error("fault moved while suspended");
  // shutdown flag registers one cycle, the output register a second
  a_junc_off: assert property (|JUNC_OVER_SHUTDOWN |-> ##2 (CH_OUT & $past(JUNC_OVER_SHUTDOWN, 2)) == '0)
    else $error("hot channel left on");
  a_case_hold: assert property (s_case_trip ##1 s_case_hot |-> (CH_OUT & $past(JUNC_OVER_SHUTDOWN, 3)) == '0)
    else $error("case shutdown released early");
  a_watchdog_off: assert property (sus_ff > WD_CYC + 2 |-> CH_OUT == '0)
    else $error("outputs on after watchdog");
endmodule
bind fts_top fts_props #(.WD_CYC(WD_CYC), .REF_CYC(REF_CYC)) props (
  .CORE_CLK(CORE_CLK), .NRST(NRST), .LOAD_N(LOAD_N), .SYNC_N(SYNC_N),
  .JUNC_OVER_SHUTDOWN(JUNC_OVER_SHUTDOWN), .CASE_OVER_SHUTDOWN(CASE_OVER_SHUTDOWN),
  .CASE_BELOW_RESET(CASE_BELOW_RESET), .XFER_CORRUPT(XFER_CORRUPT), .CH_OUT(CH_OUT),
  .FAULT_N_O(FAULT_N_O), .FAULT_N_OE(FAULT_N_OE));
